//--- sca_consts.svh
`ifndef SCA_CONSTS_SVH
`define SCA_CONSTS_SVH

// System clock rate
`define SCA_CLK_FREQ_KHZ    64'd100000
`define SCA_ACC_MOD         17'h186a0

// Internal bit-rate generator, in kbps
`define SCA_RATE_LOW_KBPS   17'h00030
`define SCA_RATE_HIGH_KBPS  17'h00040

// Streaming timeouts, in milliseconds
`define SCA_TOUT_LONG_MS    64'd32400
`define SCA_TOUT_MID_MS     64'd4000
`define SCA_TOUT_SHORT_MS   64'd500

// Sub-channel layout and behaviour
`define SCA_NUM_SUB         4
`define SCA_IDLE_BITS       16
`define SCA_BUF_DEPTH       4

// Reset values
`define SCA_IDLE_LINE       1'h1
`define SCA_TIMER_RST       32'h00000000

`endif

//--- sca_pkg.sv
package sca_pkg;

   typedef enum logic [0:0] {
      SCA_ST_IDLE      = 1'b0,
      SCA_ST_CONNECTED = 1'b1
   } sca_state_type;

   typedef enum logic [1:0] {
      SCA_CLK_INTERNAL = 2'b00,
      SCA_CLK_MAIN     = 2'b01,
      SCA_CLK_SUB1     = 2'b10
   } sca_clk_src_type;

   typedef enum logic [1:0] {
      SCA_TOUT_LONG    = 2'b00,
      SCA_TOUT_MID     = 2'b01,
      SCA_TOUT_SHORT   = 2'b10,
      SCA_TOUT_OFF     = 2'b11
   } sca_tout_type;

   typedef struct packed {
      logic ctrl;
      logic active;
      logic idle;
      logic clkLvl;
   } sca_lane_stat_type;

endpackage

//--- sca_lane.sv
`timescale 1ns/1ns
`include "sca_consts.svh"

module sca_lane #(
   parameter int DEPTH     = `SCA_BUF_DEPTH,
   parameter int IDLE_BITS = `SCA_IDLE_BITS
) (
   // Clock and reset
   input  wire logic                       clk,
   input  wire logic                       reset,
   // Sub-channel pins
   input  wire logic                       subData,
   input  wire logic                       subCtrl,
   input  wire logic                       subClk,
   // Read side, main transmit timing
   input  wire logic                       rdTick,
   input  wire logic                       rdEnable,
   // Status and buffered bit
   output sca_pkg::sca_lane_stat_type      stat,
   output logic                            rdBit
);

   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(IDLE_BITS + 1);

   generate
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || IDLE_BITS < 2) begin : g_bad_param
         $error("sca_lane: DEPTH must be a power of two and IDLE_BITS at least 2");
      end
   endgenerate

   logic [1:0]    dataS_q;
   logic [1:0]    ctrlS_q;
   logic [1:0]    clkS_q;
   logic          clkD_q;
   logic          bitPrev_q;
   logic          active_q;
   logic [CW-1:0] idleCnt_q;
   logic          mem_q [DEPTH];
   logic [AW-1:0] wrPtr_q;
   logic [AW-1:0] rdPtr_q;
   logic [AW:0]   cnt_q;
   logic          subEdge;
   logic          wrEn;
   logic          rdEn;
   logic          idleReach;

   assign subEdge   = clkS_q[1] & ~clkD_q;
   assign wrEn      = subEdge & rdEnable & (cnt_q != (AW + 1)'(DEPTH));
   assign rdEn      = rdTick & rdEnable & (cnt_q != '0);
   assign idleReach = dataS_q[1] & (idleCnt_q == CW'(IDLE_BITS - 1));

   always_ff @(posedge clk) begin
      if (reset) begin
         dataS_q <= {2{`SCA_IDLE_LINE}};
         ctrlS_q <= 2'h0;
         clkS_q  <= 2'h0;
         clkD_q  <= 1'h0;
      end else begin
         dataS_q <= {dataS_q[0], subData};
         ctrlS_q <= {ctrlS_q[0], subCtrl};
         clkS_q  <= {clkS_q[0], subClk};
         clkD_q  <= clkS_q[1];
      end
   end

   // Activity on transitions, idle after a run of mark bits
   always_ff @(posedge clk) begin
      if (reset) begin
         bitPrev_q <= `SCA_IDLE_LINE;
         active_q  <= 1'h0;
         idleCnt_q <= CW'(IDLE_BITS);
      end else if (subEdge) begin
         bitPrev_q <= dataS_q[1];
         if (idleReach) begin
            active_q <= 1'h0;
         end else if (dataS_q[1] != bitPrev_q) begin
            active_q <= 1'h1;
         end
         if (!dataS_q[1]) begin
            idleCnt_q <= '0;
         end else if (idleCnt_q != CW'(IDLE_BITS)) begin
            idleCnt_q <= idleCnt_q + CW'(1);
         end
      end
   end

   // Elastic buffer between the sub-channel clock and the main transmit clock
   always_ff @(posedge clk) begin
      if (reset || !rdEnable) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         cnt_q   <= '0;
      end else begin
         if (wrEn) begin
            mem_q[wrPtr_q] <= dataS_q[1];
            wrPtr_q        <= wrPtr_q + AW'(1);
         end
         if (rdEn) begin
            rdPtr_q <= rdPtr_q + AW'(1);
         end
         cnt_q <= cnt_q + (AW + 1)'(wrEn) - (AW + 1)'(rdEn);
      end
   end

   assign rdBit       = (cnt_q != '0) ? mem_q[rdPtr_q] : `SCA_IDLE_LINE;
   assign stat.ctrl   = ctrlS_q[1];
   assign stat.active = active_q;
   assign stat.idle   = (idleCnt_q == CW'(IDLE_BITS));
   assign stat.clkLvl = clkS_q[1];

endmodule

//--- sca_arbiter.sv
`timescale 1ns/1ns
`include "sca_consts.svh"

module sca_arbiter #(
   parameter int          NUM_SUB          = `SCA_NUM_SUB,
   parameter int          BUF_DEPTH        = `SCA_BUF_DEPTH,
   parameter int          IDLE_BITS        = `SCA_IDLE_BITS,
   parameter logic [31:0] TOUT_LONG_CYC    = 32'(`SCA_TOUT_LONG_MS * `SCA_CLK_FREQ_KHZ),
   parameter logic [31:0] TOUT_MID_CYC     = 32'(`SCA_TOUT_MID_MS * `SCA_CLK_FREQ_KHZ),
   parameter logic [31:0] TOUT_SHORT_CYC   = 32'(`SCA_TOUT_SHORT_MS * `SCA_CLK_FREQ_KHZ)
) (
   // System clock and reset
   input  wire logic                 clk,
   input  wire logic                 reset,
   // Main-channel device clock, clocks the link-side logic
   input  wire logic                 linkClk,
   // Configuration straps and front-panel buttons
   input  wire logic                 dataContention,
   input  wire logic                 rateHigh,
   input  wire logic [1:0]           clkSource,
   input  wire logic [1:0]           timeoutSelect,
   input  wire logic [NUM_SUB-1:0]   manualDisable,
   // Main channel
   input  wire logic                 mainRxData,
   output logic                      mainTxData,
   output logic                      mainTxClk,
   output logic                      mainCtrl,
   // Sub-channels
   input  wire logic [NUM_SUB-1:0]   subTxData,
   input  wire logic [NUM_SUB-1:0]   subCtrl,
   input  wire logic [NUM_SUB-1:0]   subClk,
   output logic [NUM_SUB-1:0]        subRxData,
   // Indicators and selection
   output logic [NUM_SUB-1:0]        activityLed,
   output logic [NUM_SUB-1:0]        autoDisableLed,
   output logic                      selValid,
   output logic [1:0]                selIndex
);

   generate
      if (NUM_SUB != 4 || TOUT_SHORT_CYC == 32'h0 || TOUT_MID_CYC == 32'h0 || TOUT_LONG_CYC == 32'h0) begin : g_bad
         $error("sca_arbiter: four sub-channels and non-zero timeouts are required");
      end
   endgenerate

   // ---------------- Link domain: main-channel receive ----------------
   logic [1:0] linkRstS_q;
   logic       linkRxBit_q;
   logic       linkTgl_q;

   always_ff @(posedge linkClk) begin
      linkRstS_q <= {linkRstS_q[0], reset};
   end

   always_ff @(posedge linkClk) begin
      if (linkRstS_q[1]) begin
         linkRxBit_q <= `SCA_IDLE_LINE;
         linkTgl_q   <= 1'h0;
      end else begin
         linkRxBit_q <= mainRxData;
         linkTgl_q   <= ~linkTgl_q;
      end
   end

   // ---------------- Crossing into the system domain ----------------
   logic [1:0] tglS_q;
   logic       tglD_q;
   logic       linkEvent;
   logic       rxBit_q;

   always_ff @(posedge clk) begin
      if (reset) begin
         tglS_q <= 2'h0;
         tglD_q <= 1'h0;
      end else begin
         tglS_q <= {tglS_q[0], linkTgl_q};
         tglD_q <= tglS_q[1];
      end
   end

   assign linkEvent = tglS_q[1] ^ tglD_q;

   // Receive bit is taken only after its toggle has crossed, so it is settled
   always_ff @(posedge clk) begin
      if (reset) begin
         rxBit_q <= `SCA_IDLE_LINE;
      end else if (linkEvent) begin
         rxBit_q <= linkRxBit_q;
      end
   end

   // ---------------- Configuration synchronisers ----------------
   logic [1:0]         modeS_q;
   logic [1:0]         rateS_q;
   logic [1:0]         srcS0_q;
   logic [1:0]         srcS1_q;
   logic [1:0]         toutS0_q;
   logic [1:0]         toutS1_q;
   logic [NUM_SUB-1:0] manS0_q;
   logic [NUM_SUB-1:0] manS1_q;
   logic               dataMode;
   sca_pkg::sca_clk_src_type clkSrc;
   sca_pkg::sca_tout_type    toutSel;

   always_ff @(posedge clk) begin
      if (reset) begin
         modeS_q  <= 2'h0;
         rateS_q  <= 2'h3;
         srcS0_q  <= 2'h0;
         srcS1_q  <= 2'h0;
         toutS0_q <= 2'h0;
         toutS1_q <= 2'h0;
         manS0_q  <= '0;
         manS1_q  <= '0;
      end else begin
         modeS_q  <= {modeS_q[0], dataContention};
         rateS_q  <= {rateS_q[0], rateHigh};
         srcS0_q  <= clkSource;
         srcS1_q  <= srcS0_q;
         toutS0_q <= timeoutSelect;
         toutS1_q <= toutS0_q;
         manS0_q  <= manualDisable;
         manS1_q  <= manS0_q;
      end
   end

   assign dataMode = modeS_q[1];
   assign clkSrc   = sca_pkg::sca_clk_src_type'(srcS1_q);
   assign toutSel  = sca_pkg::sca_tout_type'(toutS1_q);

   // ---------------- Transmit clock selection ----------------
   logic [16:0] phaseAcc_q;
   logic [16:0] phaseInc;
   logic [16:0] phaseSum;
   logic        intClk_q;
   logic        intRise;
   logic        sub1D_q;
   logic        sub1Rise;
   logic        txTick;
   sca_pkg::sca_lane_stat_type laneStat [NUM_SUB];
   logic [NUM_SUB-1:0]         laneBit;

   // Doubled increment wraps twice per bit period, giving both half-cycles of the clock
   assign phaseInc = rateS_q[1] ? (`SCA_RATE_HIGH_KBPS << 1) : (`SCA_RATE_LOW_KBPS << 1);
   assign phaseSum = phaseAcc_q + phaseInc;

   always_ff @(posedge clk) begin
      if (reset) begin
         phaseAcc_q <= 17'h00000;
         intClk_q   <= 1'h0;
      end else if (phaseSum >= `SCA_ACC_MOD) begin
         phaseAcc_q <= phaseSum - `SCA_ACC_MOD;
         intClk_q   <= ~intClk_q;
      end else begin
         phaseAcc_q <= phaseSum;
      end
   end

   assign intRise = (phaseSum >= `SCA_ACC_MOD) & ~intClk_q;

   always_ff @(posedge clk) begin
      if (reset) begin
         sub1D_q <= 1'h0;
      end else begin
         sub1D_q <= laneStat[0].clkLvl;
      end
   end

   assign sub1Rise = laneStat[0].clkLvl & ~sub1D_q;

   always_comb begin
      case (clkSrc)
         sca_pkg::SCA_CLK_INTERNAL: txTick = intRise;
         sca_pkg::SCA_CLK_MAIN:     txTick = linkEvent;
         sca_pkg::SCA_CLK_SUB1:     txTick = sub1Rise;
         default:                   txTick = intRise;
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         mainTxClk <= 1'h0;
      end else begin
         case (clkSrc)
            sca_pkg::SCA_CLK_INTERNAL: mainTxClk <= intClk_q;
            sca_pkg::SCA_CLK_SUB1:     mainTxClk <= laneStat[0].clkLvl;
            default:                   mainTxClk <= 1'h0;
         endcase
      end
   end

   // ---------------- Sub-channel lanes ----------------
   sca_pkg::sca_state_type state_q;
   logic [1:0]             sel_q;
   logic [NUM_SUB-1:0]     laneRead;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_SUB; gi++) begin : g_lane
         assign laneRead[gi] = (state_q == sca_pkg::SCA_ST_CONNECTED) && (sel_q == 2'(gi));
         sca_lane #(
            .DEPTH     (BUF_DEPTH),
            .IDLE_BITS (IDLE_BITS)
         ) u_lane (
            .clk      (clk),
            .reset    (reset),
            .subData  (subTxData[gi]),
            .subCtrl  (subCtrl[gi]),
            .subClk   (subClk[gi]),
            .rdTick   (txTick),
            .rdEnable (laneRead[gi]),
            .stat     (laneStat[gi]),
            .rdBit    (laneBit[gi])
         );
      end
   endgenerate

   // ---------------- Contention ----------------
   logic [NUM_SUB-1:0] autoDis_q;
   logic [NUM_SUB-1:0] request;
   logic [NUM_SUB-1:0] dropped;
   logic               anyReq;
   logic [1:0]         winner;
   logic               release_c;
   logic               timeout;

   always_comb begin
      request = '0;
      dropped = '0;
      for (int i = 0; i < NUM_SUB; i++) begin
         dropped[i] = ~laneStat[i].ctrl | laneStat[i].idle;
         request[i] = ~manS1_q[i] & ~autoDis_q[i]
                    & (dataMode ? laneStat[i].active : laneStat[i].ctrl);
      end
   end

   // Later, higher-numbered requesters overwrite earlier ones
   always_comb begin
      anyReq = 1'b0;
      winner = 2'h0;
      for (int i = 0; i < NUM_SUB; i++) begin
         if (request[i]) begin
            anyReq = 1'b1;
            winner = 2'(i);
         end
      end
   end

   always_comb begin
      if (dataMode) begin
         release_c = laneStat[sel_q].idle;
      end else begin
         release_c = ~laneStat[sel_q].ctrl;
      end
      release_c = release_c | manS1_q[sel_q] | timeout;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state_q <= sca_pkg::SCA_ST_IDLE;
         sel_q   <= 2'h0;
      end else begin
         case (state_q)
            sca_pkg::SCA_ST_IDLE: begin
               if (anyReq) begin
                  state_q <= sca_pkg::SCA_ST_CONNECTED;
                  sel_q   <= winner;
               end
            end
            sca_pkg::SCA_ST_CONNECTED: begin
               if (release_c) begin
                  state_q <= sca_pkg::SCA_ST_IDLE;
               end
            end
            default: state_q <= sca_pkg::SCA_ST_IDLE;
         endcase
      end
   end

   // ---------------- Streaming timeout ----------------
   logic [31:0] conTimer_q;
   logic [31:0] toutLimit;

   always_comb begin
      case (toutSel)
         sca_pkg::SCA_TOUT_LONG:  toutLimit = TOUT_LONG_CYC;
         sca_pkg::SCA_TOUT_MID:   toutLimit = TOUT_MID_CYC;
         sca_pkg::SCA_TOUT_SHORT: toutLimit = TOUT_SHORT_CYC;
         default:                 toutLimit = TOUT_LONG_CYC;
      endcase
   end

   assign timeout = (state_q == sca_pkg::SCA_ST_CONNECTED) && (toutSel != sca_pkg::SCA_TOUT_OFF)
                  && (conTimer_q >= toutLimit - 32'h1);

   always_ff @(posedge clk) begin
      if (reset || state_q != sca_pkg::SCA_ST_CONNECTED || release_c) begin
         conTimer_q <= `SCA_TIMER_RST;
      end else begin
         conTimer_q <= conTimer_q + 32'h1;
      end
   end

   // Setting on timeout wins over a clear in the same cycle
   always_ff @(posedge clk) begin
      if (reset) begin
         autoDis_q <= '0;
      end else begin
         for (int i = 0; i < NUM_SUB; i++) begin
            if (timeout && sel_q == 2'(i)) begin
               autoDis_q[i] <= 1'b1;
            end else if (dropped[i]) begin
               autoDis_q[i] <= 1'b0;
            end
         end
      end
   end

   // ---------------- Data paths ----------------
   logic connected;

   assign connected = (state_q == sca_pkg::SCA_ST_CONNECTED);

   always_ff @(posedge clk) begin
      if (reset) begin
         mainTxData <= `SCA_IDLE_LINE;
      end else if (txTick) begin
         mainTxData <= connected ? laneBit[sel_q] : `SCA_IDLE_LINE;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         mainCtrl <= 1'h0;
      end else begin
         mainCtrl <= connected & ~release_c & laneStat[sel_q].ctrl;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         subRxData <= {NUM_SUB{`SCA_IDLE_LINE}};
      end else begin
         subRxData <= {NUM_SUB{rxBit_q}};
      end
   end

   // ---------------- Indicators ----------------
   always_ff @(posedge clk) begin
      if (reset) begin
         activityLed    <= '0;
         autoDisableLed <= '0;
         selValid       <= 1'h0;
         selIndex       <= 2'h0;
      end else begin
         for (int i = 0; i < NUM_SUB; i++) begin
            activityLed[i] <= (connected && sel_q == 2'(i)) | laneStat[i].active;
         end
         autoDisableLed <= autoDis_q;
         selValid       <= connected;
         selIndex       <= sel_q;
      end
   end

endmodule

//--- sca_arbiter_assertions.sv
`timescale 1ns/1ns
module sca_arbiter_checker #(
   parameter int          NUM_SUB        = 4,
   parameter logic [31:0] TOUT_SHORT_CYC = 32'h00000064
) (
   // Clock and reset
   input wire logic               clk,
   input wire logic               reset,
   // Configuration
   input wire logic               dataContention,
   input wire logic [1:0]         clkSource,
   input wire logic [1:0]         timeoutSelect,
   input wire logic [NUM_SUB-1:0] manualDisable,
   // Channel pins
   input wire logic [NUM_SUB-1:0] subCtrl,
   input wire logic [NUM_SUB-1:0] subRxData,
   input wire logic               mainTxClk,
   input wire logic               mainCtrl,
   // Indicators and selection
   input wire logic [NUM_SUB-1:0] activityLed,
   input wire logic [NUM_SUB-1:0] autoDisableLed,
   input wire logic               selValid,
   input wire logic [1:0]         selIndex
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // Cycles a lane has held control high while enabled, or held it low
   logic [3:0]         hiAge [NUM_SUB];
   logic [3:0]         loAge [NUM_SUB];
   logic [NUM_SUB-1:0] reqLong;
   logic [NUM_SUB-1:0] lowLong;
   logic [31:0]        connCnt;
   logic               selCtrl;
   always_ff @(posedge clk) begin
      for (int i = 0; i < NUM_SUB; i++) begin
         if (reset) begin
            hiAge[i] <= 4'h0;
            loAge[i] <= 4'h0;
         end else begin
            hiAge[i] <= (subCtrl[i] && !manualDisable[i]) ? hiAge[i] + {3'h0, hiAge[i] != 4'hf} : 4'h0;
            loAge[i] <= subCtrl[i] ? 4'h0 : loAge[i] + {3'h0, loAge[i] != 4'hf};
         end
      end
   end
   always_ff @(posedge clk) begin
      connCnt <= (selValid && !reset) ? connCnt + 32'h1 : 32'h0;
   end
   always_comb begin
      for (int i = 0; i < NUM_SUB; i++) begin
         reqLong[i] = hiAge[i] > 4'h8;
         lowLong[i] = loAge[i] > 4'h8;
      end
   end
   assign selCtrl = subCtrl[selIndex];
   property p_grant_ctrl;
      $rose(selValid) && !dataContention |-> mainCtrl;
   endproperty
   a_grant_ctrl: assert property (p_grant_ctrl) else $error("control not routed on grant");
   property p_prio;
      $rose(selValid) && !dataContention |-> ((reqLong & ~autoDisableLed) >> selIndex) <= 4'h1;
   endproperty
   a_prio: assert property (p_prio) else $error("higher requester passed over");
   property p_release;
      !dataContention && selValid && $stable(selIndex) && $fell(selCtrl) |-> ##[1:5] !selValid;
   endproperty
   a_release: assert property (p_release) else $error("late release on control drop");
   property p_no_preempt;
      selValid && $past(selValid) |-> selIndex == $past(selIndex);
   endproperty
   a_no_preempt: assert property (p_no_preempt) else $error("connected lane preempted");
   property p_broadcast;
      subRxData == 4'h0 || subRxData == 4'hf;
   endproperty
   a_broadcast: assert property (p_broadcast) else $error("lanes see different receive bits");
   property p_tout;
      timeoutSelect == 2'h2 && selValid |-> connCnt < TOUT_SHORT_CYC;
   endproperty
   a_tout: assert property (p_tout) else $error("connection outlived short timeout");
   property p_auto_led;
      (autoDisableLed & ~$past(autoDisableLed)) != 4'h0 |-> $past(selValid) && !selValid;
   endproperty
   a_auto_led: assert property (p_auto_led) else $error("auto-disable without release");
   property p_auto_clear;
      !dataContention |-> (autoDisableLed & lowLong) == 4'h0;
   endproperty
   a_auto_clear: assert property (p_auto_clear) else $error("auto-disable kept after drop");
   property p_activity;
      selValid && $past(selValid) |-> activityLed[selIndex];
   endproperty
   a_activity: assert property (p_activity) else $error("connected lane not shown active");
   property p_clk_main;
      clkSource == 2'h1 && $past(clkSource, 6) == 2'h1 |-> !mainTxClk;
   endproperty
   a_clk_main: assert property (p_clk_main) else $error("clock driven in main source");
   c_grant: cover property ($rose(selValid));
   c_auto: cover property (autoDisableLed != 4'h0);
   c_data: cover property (dataContention && selValid);
endmodule
bind sca_arbiter sca_arbiter_checker #(.NUM_SUB(NUM_SUB), .TOUT_SHORT_CYC(TOUT_SHORT_CYC)) sca_arbiter_checker_i (
   .clk, .reset, .dataContention, .clkSource, .timeoutSelect, .manualDisable, .subCtrl, .subRxData,
   .mainTxClk, .mainCtrl, .activityLed, .autoDisableLed, .selValid, .selIndex);

//--- sca_sub_model.sv
`timescale 1ns/1ns
module sca_sub_model (
   // Far-side pins of the four lanes
   output logic [3:0] subTxData,
   output logic [3:0] subClk
);
   // Lines mark idle and clocks stand still between frames
   initial begin
      subTxData = 4'hf;
      subClk    = 4'h0;
   end
   // First bit first; data moves while the clock is low
   task automatic send(input int lane, input logic [31:0] bits);
      for (int k = 0; k < 32; k++) begin
         subTxData[lane] = bits[k];
         #200;
         subClk[lane] = 1'b1;
         #200;
         subClk[lane] = 1'b0;
      end
      subTxData[lane] = 1'b1;
   endtask
endmodule

//--- sca_arbiter_test.sv
`timescale 1ns/1ns
`define CHK(nm, g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; $display("BAD %s exp %h got %h", nm, e, g); end end
module sca_arbiter_test;
   logic       clk            = 1'b0;
   logic       reset          = 1'b1;
   logic       linkClk        = 1'b0;
   logic       dataContention = 1'b0;
   logic       rateHigh       = 1'b0;
   logic [1:0] clkSource      = 2'h0;
   logic [1:0] timeoutSelect  = 2'h0;
   logic [3:0] manualDisable  = 4'h0;
   logic       mainRxData     = 1'b1;
   logic [3:0] subCtrl        = 4'h0;
   logic [3:0] pat            = 4'h6;
   logic [3:0] subTxData, subClk, subRxData, activityLed, autoDisableLed;
   logic       mainTxData, mainTxClk, mainCtrl, selValid, txPrev;
   logic [1:0] selIndex;
   int         miscompares    = 0;
   int         n_tests        = 0;
   int         txRises        = 0;
   int         lowSeen        = 0;
   int         k;
   int         lim [4]        = '{32'h190, 32'hc8, 32'h64, 32'h258};
   always #5 clk = ~clk;
   initial begin
      #5;
      forever #16 linkClk = ~linkClk;
   end
   always @(posedge clk) begin
      txPrev <= mainTxClk;
      if (mainTxClk === 1'b1 && txPrev === 1'b0) txRises <= txRises + 1;
      if (mainTxData === 1'b0) lowSeen <= lowSeen + 1;
   end
   sca_arbiter #(
      .TOUT_LONG_CYC (32'h00000190),
      .TOUT_MID_CYC  (32'h000000c8),
      .TOUT_SHORT_CYC(32'h00000064)
   ) sca_arbiter_i (
      .clk, .reset, .linkClk, .dataContention, .rateHigh, .clkSource, .timeoutSelect, .manualDisable,
      .mainRxData, .mainTxData, .mainTxClk, .mainCtrl, .subTxData, .subCtrl, .subClk, .subRxData,
      .activityLed, .autoDisableLed, .selValid, .selIndex);
   sca_sub_model sca_sub_model_i (.subTxData, .subClk);
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic wait_sel(input logic v, input int n);
      for (int i = 0; i < n && selValid !== v; i++) @(negedge clk);
   endtask
   task automatic done(input string nm);
      $display("test %s finished", nm);
   endtask
   task automatic give_verdict();
      $display("%0d comparisons, %0d mismatches", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      #500000;
      miscompares++;
      give_verdict();
   end
   initial begin
      // Link side stretches reset through its own two-stage synchroniser
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      cyc(1);
      `CHK("reset", {mainTxData, subRxData, selValid, mainCtrl, activityLed, autoDisableLed}, {1'h1, 4'hf, 10'h000})
      done("reset");
      @(posedge clk) subCtrl <= 4'ha;
      wait_sel(1'b1, 10);
      `CHK("prio", {selIndex, mainCtrl, activityLed}, {2'h3, 1'h1, 4'h8})
      @(posedge clk) subCtrl <= 4'he;
      cyc(10);
      `CHK("hold", selIndex, 2'h3)
      @(posedge clk) subCtrl <= 4'h6;
      wait_sel(1'b0, 5);
      `CHK("drop", selValid, 1'b0)
      wait_sel(1'b1, 10);
      `CHK("next", selIndex, 2'h2)
      @(posedge clk) manualDisable <= 4'h4;
      wait_sel(1'b0, 10);
      wait_sel(1'b1, 10);
      `CHK("mdis", {selValid, selIndex}, {1'h1, 2'h1})
      @(posedge clk) begin
         subCtrl       <= 4'h0;
         manualDisable <= 4'h0;
      end
      cyc(10);
      done("control");
      for (int s = 0; s < 4; s++) begin
         @(posedge clk) timeoutSelect <= 2'(s);
         cyc(10);
         @(posedge clk) subCtrl <= 4'h1;
         wait_sel(1'b1, 10);
         k = 0;
         while (selValid === 1'b1 && k < 600) begin
            @(negedge clk);
            k++;
         end
         `CHK("tout", k, lim[s])
         `CHK("aled", autoDisableLed, (s == 3) ? 4'h0 : 4'h1)
         @(posedge clk) subCtrl <= 4'h0;
         cyc(12);
         `CHK("aclr", {autoDisableLed, selValid}, 5'h00)
      end
      done("timeout");
      @(posedge clk) begin
         dataContention <= 1'b1;
         clkSource      <= sca_pkg::SCA_CLK_SUB1;
      end
      cyc(10);
      txRises = 0;
      lowSeen = 0;
      sca_sub_model_i.send(0, 32'hffff5555);
      cyc(10);
      `CHK("txclk", txRises, 32)
      `CHK("txdata", lowSeen > 0, 1'b1)
      fork
         sca_sub_model_i.send(1, 32'hffff5555);
         sca_sub_model_i.send(2, 32'hffff5555);
         begin
            cyc(400);
            `CHK("dsel", {selValid, selIndex, activityLed[2]}, {1'h1, 2'h2, 1'h1})
         end
      join
      wait_sel(1'b0, 40);
      `CHK("didle", selValid, 1'b0)
      @(posedge clk) dataContention <= 1'b0;
      done("data");
      for (int b = 0; b < 4; b++) begin
         @(posedge linkClk) mainRxData <= pat[b];
         cyc(20);
         `CHK("bcast", subRxData, {4{pat[b]}})
      end
      done("broadcast");
      for (int r = 0; r < 2; r++) begin
         @(posedge clk) begin
            clkSource <= sca_pkg::SCA_CLK_INTERNAL;
            rateHigh  <= r[0];
         end
         cyc(10);
         txRises = 0;
         cyc(12500);
         `CHK("rate", txRises >= 5 + 2 * r && txRises <= 7 + 2 * r, 1'b1)
      end
      @(posedge clk) clkSource <= sca_pkg::SCA_CLK_MAIN;
      cyc(10);
      txRises = 0;
      cyc(500);
      `CHK("mainclk", txRises, 0)
      done("clock");
      give_verdict();
   end
endmodule
